// *** verilog/sram_arb_device.sv ***
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
// Overview of operation
// - Processor-written page register drives upper SRAM address
// - Wait states after page write, then zero
// - Page held static, no per-access decoding
// - Host accesses take upper bits from host
// - Own chip select follows processor strobe
// - Hold request high means processor owns bus
// - Drive strobe low for granted host access
// - Host has absolute priority over processor
// - Hold on standard mode, host access, manual hold
// - Processor finishes access, then grants hold
// - Smart mode blocks host until hold grant
// - Standard mode lets host run regardless
// - Time out stalled host access, flag status
// - Ready low while transaction cannot complete
// - Processor software sets seven non-SRAM wait states (the processor model here holds an I/O write only while cpu_ready is low)
// - Processor leaves dead cycle after non-SRAM access
// - Or processor uses one SRAM wait state
// - Host wait stretched until hold grant
// - Timeout flag kept until valid host access
module sram_arb_device
  import sram_arb_pkg::*;
#(
  parameter int PAGE_W = 8
) (
  input wire logic pclk, // Card clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  sram_arb_if.dev link // Processor and host link
);
  typedef struct packed {
    logic [PAGE_W-1:0] page;
    logic [3:0] swap_cnt;
    logic [15:0] tmo_cnt;
    logic timeout_flag;
    logic standard_mode;
    logic manual_hold;
    logic io_pend;
    logic [31:0] rdata;
  } state_t;
  state_t s_reg, s_next;
  logic host_go;
  logic [15:0] apb_word;

  // Host may proceed in standard mode or once grant is seen
  assign host_go = s_reg.standard_mode || !link.bus_hold_grant_n;
  assign apb_word = 16'(paddr);

  always_comb begin
    s_next = s_reg;
    // Page register write from processor I/O space; static between writes
    if (!link.io_space_strobe_n && link.io_wr && link.cpu_addr == PAGE_IO_ADDR &&
        s_reg.swap_cnt == 4'h0) begin
      s_next.page = link.cpu_wdata[PAGE_W-1:0];
      s_next.swap_cnt = 4'(PAGE_SWAP_WAITS);
    end else if (s_reg.swap_cnt != 4'h0) begin
      s_next.swap_cnt = s_reg.swap_cnt - 4'h1;
    end
    // Timeout counter runs from start of a stalled host access
    if (link.host_req && !host_go) begin
      if (s_reg.tmo_cnt >= 16'(TIMEOUT_CYCLES - 1)) begin
        s_next.timeout_flag = 1'b1;
      end else begin
        s_next.tmo_cnt = s_reg.tmo_cnt + 16'h1;
      end
    end else begin
      s_next.tmo_cnt = 16'h0;
    end
    // Flag cleared only by a valid access; new timeout wins
    if (link.host_req && host_go && s_reg.tmo_cnt < 16'(TIMEOUT_CYCLES - 1)) begin
      s_next.timeout_flag = 1'b0;
    end
    // APB register writes in the access phase; read data sampled in the setup phase
    if (psel && penable && pwrite && apb_word == 16'(CTRL_OFFSET)) begin
      s_next.standard_mode = pwdata[CTRL_STANDARD_BIT];
      s_next.manual_hold = pwdata[CTRL_MANUAL_HOLD_BIT];
    end
    s_next.rdata = 32'h0;
    if (psel && !penable && !pwrite) begin
      if (paddr == CTRL_OFFSET) begin
        s_next.rdata[CTRL_STANDARD_BIT] = s_reg.standard_mode;
        s_next.rdata[CTRL_MANUAL_HOLD_BIT] = s_reg.manual_hold;
      end else if (paddr == STATUS_OFFSET) begin
        s_next.rdata[STAT_TIMEOUT_BIT] = s_reg.timeout_flag;
        s_next.rdata[STAT_GRANT_BIT] = !link.bus_hold_grant_n;
        s_next.rdata[STAT_PAGE_LSB +: PAGE_W] = s_reg.page;
      end
    end
    s_next.io_pend = 1'b0;
  end

  // Registered read data, answer in the access phase
  assign prdata = s_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && paddr != CTRL_OFFSET && paddr != STATUS_OFFSET;

  // Hold request; host pre-empts processor after its cycle ends
  assign link.hold_req_n = !(s_reg.standard_mode || link.host_req ||
                             s_reg.manual_hold);
  // Stretch host cycle until allowed
  assign link.host_wait = link.host_req && !host_go;
  // Upper address: host page during host access, else page register
  assign link.sram_upper = (link.host_req && host_go) ? link.host_page : s_reg.page;
  // Our chip select tracks processor strobe or a host cycle allowed to run (standard mode or granted).
  // Follow the strobe until the grant: the processor may still be finishing
  // its access after the hold request has gone low.
  assign link.sram_cs_n = !((link.bus_hold_grant_n && !link.strobe_line) ||
                            (link.host_req && host_go));
  // Drive strobe low only when the processor has let go of it
  assign link.strobe_dev_o = 1'b0;
  assign link.strobe_dev_oe = link.host_req && !link.bus_hold_grant_n;
  // Ready held low through the bank swap
  assign link.cpu_ready = s_reg.swap_cnt == 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.page <= PAGE_RESET[PAGE_W-1:0];
    end else begin
      s_reg <= s_next;
    end
  end
endmodule // sram_arb_device

// *** common/sram_arb_pkg.sv ***
package sram_arb_pkg;
  // Card clock figures
  localparam int CLK_PERIOD_NS = 20;
  // Host access timeout, kept under the host's 1.2 us limit
  localparam int HOST_TIMEOUT_NS = 1000;
  localparam int TIMEOUT_CYCLES = HOST_TIMEOUT_NS / CLK_PERIOD_NS;
  // Wait states inserted after a page register write
  localparam int PAGE_SWAP_WAITS = 3;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  // Processor-side wait-state generator default after reset
  localparam int CPU_SW_WAIT_DEFAULT = 7;
  // Processor I/O address of the page register
  localparam logic [15:0] PAGE_IO_ADDR = 16'h0050;
  // Controller register byte offsets on APB
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  // Control register bit positions
  localparam int CTRL_STANDARD_BIT = 0;
  localparam int CTRL_MANUAL_HOLD_BIT = 1;
  localparam int CTRL_IOWRITE_BIT = 2;
  localparam int CTRL_IODATA_LSB = 8;
  // Status register bit positions
  localparam int STAT_TIMEOUT_BIT = 0;
  localparam int STAT_GRANT_BIT = 1;
  localparam int STAT_IOBUSY_BIT = 2;
  localparam int STAT_PAGE_LSB = 8;
endpackage

// *** common/sram_arb_if.sv ***
`timescale 1ns/1ps
interface sram_arb_if #(parameter int PAGE_W = 8);
  logic host_req;
  logic host_wait;
  logic [PAGE_W-1:0] host_page;
  logic hold_req_n;
  logic bus_hold_grant_n;
  logic strobe_cpu_o;
  logic strobe_cpu_oe;
  logic strobe_dev_o;
  logic strobe_dev_oe;
  logic strobe_line;
  logic io_space_strobe_n;
  logic io_wr;
  logic [15:0] cpu_addr;
  logic [7:0] cpu_wdata;
  logic cpu_ready;
  logic [PAGE_W-1:0] sram_upper;
  logic sram_cs_n;
  // Shared strobe line with pullup: low if either end drives low
  assign strobe_line = !((strobe_cpu_oe && !strobe_cpu_o) || (strobe_dev_oe && !strobe_dev_o));
  modport dev (input host_req, host_page, bus_hold_grant_n, strobe_line, io_space_strobe_n,
    io_wr, cpu_addr, cpu_wdata, output host_wait, hold_req_n, strobe_dev_o, strobe_dev_oe,
    cpu_ready, sram_upper, sram_cs_n);
  modport cpu (output bus_hold_grant_n, strobe_cpu_o, strobe_cpu_oe, io_space_strobe_n, io_wr,
    cpu_addr, cpu_wdata, host_req, host_page, input hold_req_n, cpu_ready, strobe_line,
    host_wait);
endinterface

// *** verilog/sram_arb_cpu.sv ***
`timescale 1ns/1ps
// Processor-side end: grants hold after its own access finishes,
// and issues I/O writes to the page register on request.
module sram_arb_cpu
  import sram_arb_pkg::*;
(
  input wire logic pclk, // Card clock
  input wire logic presetn, // Async reset, active low
  input wire logic mem_req, // Start one SRAM access
  input wire logic io_req, // Start one page register write
  input wire logic [7:0] io_data, // Page value to write
  input wire logic host_req, // Host wants memory
  input wire logic [7:0] host_page, // Host upper address
  output logic busy, // Access in progress
  sram_arb_if.cpu link // Link to device
);
  typedef enum logic [1:0] {IDLE, MEM, IOW, HELD} st_t;
  typedef struct packed {
    st_t st;
    logic dead;
  } state_t;
  state_t s_reg, s_next;

  // Finish current access before granting; dead cycle after I/O
  always_comb begin
    s_next = s_reg;
    s_next.dead = 1'b0;
    case (s_reg.st)
      IDLE: begin
        if (!link.hold_req_n) begin
          s_next.st = HELD;
        end else if (io_req) begin
          s_next.st = IOW;
        end else if (mem_req && !s_reg.dead) begin
          s_next.st = MEM;
        end
      end
      MEM: begin
        s_next.st = IDLE;
      end
      IOW: begin
        // Non-SRAM access stretches as long as ready stays low
        if (link.cpu_ready) begin
          s_next.st = IDLE;
          s_next.dead = 1'b1;
        end
      end
      HELD: begin
        if (link.hold_req_n) begin
          s_next.st = IDLE;
        end
      end
      default: s_next.st = IDLE;
    endcase
  end

  assign link.bus_hold_grant_n = !(s_reg.st == HELD);
  assign link.strobe_cpu_o = 1'b0;
  assign link.strobe_cpu_oe = s_reg.st == MEM;
  assign link.io_space_strobe_n = !(s_reg.st == IOW);
  assign link.io_wr = s_reg.st == IOW;
  assign link.cpu_addr = PAGE_IO_ADDR;
  assign link.cpu_wdata = io_data;
  assign link.host_req = host_req;
  assign link.host_page = host_page;
  assign busy = s_reg.st != IDLE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule // sram_arb_cpu

// *** tb/sram_arb_chk.sv ***
`timescale 1ns/1ps
module sram_arb_chk
  import sram_arb_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic host_req, // Host wants SRAM
  input wire logic host_wait, // Host stretch
  input wire logic [7:0] host_page, // Host page
  input wire logic hold_req_n, // Hold request
  input wire logic bus_hold_grant_n, // Hold grant
  input wire logic strobe_dev_o, // Device strobe
  input wire logic strobe_dev_oe, // Strobe enable
  input wire logic strobe_line, // Shared strobe
  input wire logic io_space_strobe_n, // I/O strobe
  input wire logic io_wr, // I/O write
  input wire logic [15:0] cpu_addr, // CPU address
  input wire logic cpu_ready, // CPU ready
  input wire logic [7:0] sram_upper, // Upper address
  input wire logic sram_cs_n // Chip select
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Arbitration and strobe relations, all combinational answers
  property p_hold; host_req |-> !hold_req_n; endproperty
  a_hold: assert property (p_hold) else $error("no hold on host access");
  property p_wait; host_wait |-> host_req && bus_hold_grant_n; endproperty
  a_wait: assert property (p_wait) else $error("wait without stall");
  property p_go; host_req && !bus_hold_grant_n |-> !host_wait; endproperty
  a_go: assert property (p_go) else $error("wait after grant");
  property p_drv; host_req && !host_wait && !bus_hold_grant_n |-> strobe_dev_oe && !strobe_dev_o;
  endproperty
  a_drv: assert property (p_drv) else $error("strobe not driven");
  property p_own; strobe_dev_oe |-> !hold_req_n && !bus_hold_grant_n; endproperty
  a_own: assert property (p_own) else $error("strobe driven while cpu owns");
  property p_cs; !strobe_line |-> !sram_cs_n; endproperty
  a_cs: assert property (p_cs) else $error("chip select missing");
  property p_hpage; host_req && !host_wait |-> sram_upper == host_page; endproperty
  a_hpage: assert property (p_hpage) else $error("host page wrong");
  // Page write stalls three cycles, then ready returns for zero-wait use
  property p_swap;
    $fell(io_space_strobe_n) && io_wr && cpu_addr == PAGE_IO_ADDR && cpu_ready
      |=> !cpu_ready [*3] ##1 cpu_ready;
  endproperty
  a_swap: assert property (p_swap) else $error("swap waits wrong");
  c_host: cover property (host_req && !host_wait);
  c_stall: cover property (host_wait);
  c_swap: cover property (!cpu_ready);
endmodule // sram_arb_chk

// *** tb/shared_sram_arbiter_pager_tb_top.sv ***
`timescale 1ns/1ps
module shared_sram_arbiter_pager_tb_top;
  import sram_arb_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, serr;
  logic mem_req = 0, io_req = 0, host_req = 0, pready, pslverr, busy;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h94CA8DAD;
  logic [7:0] io_data = 8'h00, host_page = 8'h00, mpage;
  int err_total = 0, checks_done = 0, cyc = 0;
  sram_arb_if #(.PAGE_W(8)) lnk();
  sram_arb_device #(.PAGE_W(8)) sram_arb_device_inst(.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lnk.dev));
  sram_arb_cpu sram_arb_cpu_inst(.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .io_req(io_req), .io_data(io_data), .host_req(host_req), .host_page(host_page),
    .busy(busy), .link(lnk.cpu));
  sram_arb_chk chk_i(.pclk(pclk), .presetn(presetn), .host_req(lnk.host_req),
    .host_wait(lnk.host_wait), .host_page(lnk.host_page), .hold_req_n(lnk.hold_req_n),
    .bus_hold_grant_n(lnk.bus_hold_grant_n), .strobe_dev_o(lnk.strobe_dev_o),
    .strobe_dev_oe(lnk.strobe_dev_oe), .strobe_line(lnk.strobe_line),
    .io_space_strobe_n(lnk.io_space_strobe_n), .io_wr(lnk.io_wr), .cpu_addr(lnk.cpu_addr),
    .cpu_ready(lnk.cpu_ready), .sram_upper(lnk.sram_upper), .sram_cs_n(lnk.sram_cs_n));
  // Clock, and a watchdog so a lost grant cannot hang the run
  initial begin
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      end_of_test();
    end
  end
  function logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task end_of_test;
    $display("errors=%0d checks=%0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One APB transfer; data and error taken at the ready edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; serr = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // Level request held until the processor end reports busy, then drained
  task cpu_op(input logic io, input logic [7:0] v);
    io_data <= v; io_req <= io; mem_req <= !io;
    do @(posedge pclk); while (busy !== 1'b1);
    io_req <= 0; mem_req <= 0;
    do @(posedge pclk); while (busy !== 1'b0);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    apb(0, STATUS_OFFSET, 32'h0);
    chk(rd, 32'h0);
    apb(0, 12'h008, 32'h0);
    chk(serr, 1'b1);
    // Random pages, then a host access that must win over a simultaneous processor memory request
    repeat (4) begin
      seed = xs(seed); mpage = seed[7:0];
      cpu_op(1, mpage);
      chk(lnk.sram_upper, mpage);
      cpu_op(0, 8'h00);
      apb(0, STATUS_OFFSET, 32'h0);
      chk(rd[15:8], mpage);
      chk(rd[0], 1'b0);
      seed = xs(seed);
      host_page <= seed[7:0]; host_req <= 1; mem_req <= 1;
      do @(posedge pclk); while (lnk.bus_hold_grant_n !== 1'b0 || lnk.host_wait !== 1'b0);
      chk(lnk.sram_upper, host_page);
      chk({lnk.sram_cs_n, lnk.strobe_line}, 2'b00);
      host_req <= 0; mem_req <= 0;
      repeat (2) @(posedge pclk);
      chk(lnk.hold_req_n, 1'b1);
      chk(lnk.sram_upper, mpage);
    end
    // Standard mode and manual hold both keep hold requested
    for (logic [2:0] m = 1; m < 4; m++) begin
      apb(1, CTRL_OFFSET, {29'h0, m});
      @(posedge pclk);
      chk(lnk.hold_req_n, 1'b0);
    end
    apb(1, CTRL_OFFSET, 32'h0);
    @(posedge pclk);
    chk(lnk.hold_req_n, 1'b1);
    end_of_test();
  end
endmodule // shared_sram_arbiter_pager_tb_top
